// *** inc/surge_opts_params.svh ***
// Constants for the peak power and protection option register
// How it works
// - Overload time codes 1/2/10/20 ms, default 00b
// - Input-overshoot trigger only when its enable set
// - Undershoot trigger only when its enable set
// - Overload flag shows cycle; write zero exits
// - Relax flag shows cycle; write zero exits
// - Cycle time codes 5/10/20/40 ms, default 10b
// - Overload as long as cycle or longer means no relax
// - Pin limit enable picks lower limit value
// - Monitor select: zero discharge, one charge
// - Low switch threshold 210 or 150 mV
// - Input threshold 280 or 150 mV
// - Input overcurrent past 100 us disables converter when enabled
// - Input ratio 133 or 200 percent
// - Discharge overcurrent disables converter when enabled
// - Discharge ratio 133 or 200 percent
`ifndef SURGE_OPTS_PARAMS_SVH
`define SURGE_OPTS_PARAMS_SVH
`define OPT_REG_OFFSET 8'h32
`define OPT_REG_RESET 16'h02B7
`define BIT_OVLD_HI 15
`define BIT_OVLD_LO 14
`define BIT_TRIG_IN 13
`define BIT_TRIG_SYS 12
`define BIT_OVLD_FLAG 11
`define BIT_RELAX_FLAG 10
`define BIT_TMAX_HI 9
`define BIT_TMAX_LO 8
`define BIT_PIN_LIM 7
`define BIT_MON_DIR 6
`define BIT_LOWSW 5
`define BIT_INOC_SEL 4
`define BIT_INOC_EN 3
`define BIT_INOC_RATIO 2
`define BIT_DSOC_EN 1
`define BIT_DSOC_RATIO 0
`define CLK_HZ 10000000
`define MS_CYCLES (`CLK_HZ / 1000)
`define BLANK_US 100
`define BLANK_CYCLES ((`BLANK_US * `CLK_HZ) / 1000000)
`define OVLD_MS_0 1
`define OVLD_MS_1 2
`define OVLD_MS_2 10
`define OVLD_MS_3 20
`define TMAX_MS_0 5
`define TMAX_MS_1 10
`define TMAX_MS_2 20
`define TMAX_MS_3 40
`define LOWSW_MV_0 210
`define LOWSW_MV_1 150
`define INOC_MV_0 280
`define INOC_MV_1 150
`define RATIO_PCT_0 133
`define RATIO_PCT_1 200
`endif

// *** inc/surge_opts_pkg.sv ***
// Types for the peak power and protection option register
package surge_opts_pkg;
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_wr_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OVLD = 3'b010,
    ST_RELAX = 3'b100
  } surge_state_t;
endpackage

// *** verif/host_port_model.sv ***
// Host-side register writer feeding the option register
`timescale 1ns/1ps
module host_port_model (
  input wire logic clk_in,
  output logic wr_en_out,
  output logic [7:0] addr_out,
  output logic [15:0] wdata_out
);
  initial begin
    wr_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 16'h0000;
  end
  // host writes word d at address a
  // Whole word per strobe; data parked inverted so no stale value lingers
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wdata_out <= ~d;
  endtask
endmodule // host_port_model

// *** verif/tb.sv ***
// Self-checking bench for the option register and peak power sequencer
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, adp, ovs, uds, ioc, doc, wr, mon, surge, cdis;
  logic [7:0] addr, lsw, ir, dr;
  logic [8:0] imv;
  logic [15:0] wd, pin, regl, rd, lim, w, p, r;
  logic [19:0] n;
  logic [19:0] notes[$];
  int failures = 0;
  int n_compared = 0;

  host_port_model host (.clk_in(clk), .wr_en_out(wr), .addr_out(addr), .wdata_out(wd));
  // Short ms tick and blank-out keep the run brief
  surge_opts_reg #(.MS_DIV(10), .BLANK(5)) dut (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .WR_EN_IN(wr), .ADDR_IN(addr), .WDATA_IN(wd),
    .ADAPTER_PRESENT_IN(adp), .INPUT_OVERSHOOT_IN(ovs), .SYSVOLT_UNDERSHOOT_IN(uds),
    .INPUT_OC_DETECT_IN(ioc), .DISCHARGE_OC_DETECT_IN(doc), .PIN_LIMIT_IN(pin),
    .REG_LIMIT_IN(regl), .RDATA_OUT(rd), .INPUT_LIMIT_OUT(lim), .MONITOR_CHARGE_OUT(mon),
    .LOWSW_OC_MV_OUT(lsw), .INPUT_OC_MV_OUT(imv), .INPUT_OC_RATIO_PCT_OUT(ir),
    .DISCHARGE_OC_RATIO_PCT_OUT(dr), .SURGE_ACTIVE_OUT(surge), .CONVERTER_DISABLE_OUT(cdis));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] obs(input logic [3:0] s);
    case (s)
      0: obs = rd;
      1: obs = lim;
      2: obs = {15'h0000, mon};
      3: obs = {8'h00, lsw};
      4: obs = {7'h00, imv};
      5: obs = {8'h00, ir};
      6: obs = {8'h00, dr};
      7: obs = {15'h0000, surge};
      default: obs = {15'h0000, cdis};
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic note(input logic [3:0] s, input logic [15:0] v);
    notes.push_back({s, v});
  endtask
  // Notes are drained mid-cycle, where outputs have settled
  always @(negedge clk) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check(obs(n[19:16]), n[15:0]);
    end
  end
  task automatic wait_for(input logic [3:0] s, input logic [15:0] v, input int mx);
    for (int i = 0; i < mx; i++) begin
      @(posedge clk);
      #10;
      if (obs(s) === v) break;
    end
    note(s, v);
  endtask
  task automatic hold(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic trig(input logic a, input logic b);
    @(posedge clk);
    ovs <= a;
    uds <= b;
    @(posedge clk);
    ovs <= 1'b0;
    uds <= 1'b0;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    hold(12);
    rst_n <= 1'b1;
    note(0, 16'h02B7);
    note(3, 16'h0096);
    note(4, 16'h0096);
    note(5, 16'h00C8);
    note(6, 16'h00C8);
    note(2, 16'h0000);
  endtask
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    failures++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    adp = 1'b1;
    {ovs, uds, ioc, doc} = 4'h0;
    pin = 16'h0000;
    regl = 16'h0000;
    void'($urandom(9));
    do_reset();
    // Random words with flags and triggers clear
    for (int k = 0; k < 8; k++) begin
      w = 16'($urandom) & 16'hC3FF;
      p = 16'($urandom);
      r = 16'($urandom);
      pin <= p;
      regl <= r;
      host.write(8'h32, w);
      @(posedge clk);
      note(0, w);
      note(1, w[7] ? ((p < r) ? p : r) : r);
      note(2, {15'h0000, w[6]});
      note(3, w[5] ? 16'h0096 : 16'h00D2);
      note(4, w[4] ? 16'h0096 : 16'h0118);
      note(5, w[2] ? 16'h00C8 : 16'h0085);
      note(6, w[0] ? 16'h00C8 : 16'h0085);
    end
    // Unmapped address leaves the word alone
    host.write(8'h33, ~w);
    @(posedge clk);
    note(0, w);
    host.write(8'h32, 16'h0000);
    trig(1'b1, 1'b1);
    hold(3);
    note(7, 16'h0000);
    host.write(8'h32, 16'h1000);
    trig(1'b1, 1'b0);
    hold(3);
    note(7, 16'h0000);
    trig(1'b0, 1'b1);
    wait_for(7, 16'h0001, 3);
    host.write(8'h32, 16'h1000);
    wait_for(7, 16'h0000, 3);
    host.write(8'h32, 16'h2000);
    trig(1'b1, 1'b0);
    wait_for(0, 16'h2800, 3);
    wait_for(0, 16'h2400, 15);
    wait_for(0, 16'h2000, 60);
    trig(1'b1, 1'b0);
    wait_for(0, 16'h2400, 20);
    host.write(8'h32, 16'h2000);
    wait_for(0, 16'h2000, 3);
    host.write(8'h32, 16'hE000);
    trig(1'b1, 1'b0);
    wait_for(7, 16'h0001, 3);
    hold(150);
    note(7, 16'h0001);
    wait_for(7, 16'h0000, 80);
    note(0, 16'hE000);
    adp <= 1'b0;
    hold(2);
    note(0, 16'hC000);
    adp <= 1'b1;
    do_reset();
    doc <= 1'b1;
    wait_for(8, 16'h0001, 4);
    doc <= 1'b0;
    do_reset();
    host.write(8'h32, 16'h0008);
    doc <= 1'b1;
    hold(5);
    note(8, 16'h0000);
    doc <= 1'b0;
    ioc <= 1'b1;
    hold(4);
    note(8, 16'h0000);
    wait_for(8, 16'h0001, 6);
    hold(2);
    print_verdict();
  end
endmodule // tb

// *** verilog/surge_opts_reg.sv ***
// Peak power mode and overcurrent option register with its sequencer
`timescale 1ns/1ps
`include "surge_opts_params.svh"
module surge_opts_reg
  import surge_opts_pkg::*;
#(
  parameter int MS_DIV = `MS_CYCLES,
  parameter int BLANK = `BLANK_CYCLES
) (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic WR_EN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic ADAPTER_PRESENT_IN,
  input wire logic INPUT_OVERSHOOT_IN,
  input wire logic SYSVOLT_UNDERSHOOT_IN,
  input wire logic INPUT_OC_DETECT_IN,
  input wire logic DISCHARGE_OC_DETECT_IN,
  input wire logic [15:0] PIN_LIMIT_IN,
  input wire logic [15:0] REG_LIMIT_IN,
  output logic [15:0] RDATA_OUT,
  output logic [15:0] INPUT_LIMIT_OUT,
  output logic MONITOR_CHARGE_OUT,
  output logic [7:0] LOWSW_OC_MV_OUT,
  output logic [8:0] INPUT_OC_MV_OUT,
  output logic [7:0] INPUT_OC_RATIO_PCT_OUT,
  output logic [7:0] DISCHARGE_OC_RATIO_PCT_OUT,
  output logic SURGE_ACTIVE_OUT,
  output logic CONVERTER_DISABLE_OUT
);
  // ----------------------------------------
  // Register, decode and sequencer state
  // ----------------------------------------
  reg_wr_t wr;
  logic [15:0] opt_r;
  logic [15:0] opt_nxt;
  surge_state_t st_r;
  surge_state_t st_nxt;
  logic [5:0] ms_r;
  logic [15:0] blank_r;
  logic adapter_d_r;
  logic tick;
  assign wr = '{wr_en: WR_EN_IN, addr: ADDR_IN, wdata: WDATA_IN};
  wire hit = wr.wr_en && (wr.addr == `OPT_REG_OFFSET);
  wire adapter_gone = adapter_d_r && !ADAPTER_PRESENT_IN;
  // Overload and cycle durations in ms
  wire [1:0] ov_code = opt_r[`BIT_OVLD_HI:`BIT_OVLD_LO];
  wire [1:0] tm_code = opt_r[`BIT_TMAX_HI:`BIT_TMAX_LO];
  wire [5:0] ov_ms = (ov_code == 2'h0) ? 6'(`OVLD_MS_0) : (ov_code == 2'h1) ? 6'(`OVLD_MS_1) :
                     (ov_code == 2'h2) ? 6'(`OVLD_MS_2) : 6'(`OVLD_MS_3);
  wire [5:0] tm_ms = (tm_code == 2'h0) ? 6'(`TMAX_MS_0) : (tm_code == 2'h1) ? 6'(`TMAX_MS_1) :
                     (tm_code == 2'h2) ? 6'(`TMAX_MS_2) : 6'(`TMAX_MS_3);
  // No relax when overload lasts as long as the cycle or longer
  wire no_relax = ov_ms >= tm_ms;
  wire [5:0] relax_ms = no_relax ? 6'h00 : 6'(tm_ms - ov_ms);
  wire trig_in = opt_r[`BIT_TRIG_IN] && INPUT_OVERSHOOT_IN;
  wire trig_sys = opt_r[`BIT_TRIG_SYS] && SYSVOLT_UNDERSHOOT_IN;
  // Both enables clear keeps mode off
  wire trig = (trig_in || trig_sys) && ADAPTER_PRESENT_IN;
  wire mode_en = opt_r[`BIT_TRIG_IN] || opt_r[`BIT_TRIG_SYS];
  // Host zero writes to the status flags
  wire clr_ovld = hit && !wr.wdata[`BIT_OVLD_FLAG];
  wire clr_relax = hit && !wr.wdata[`BIT_RELAX_FLAG];
  wire ms_done = tick && (ms_r <= 6'h01);
  wire ms_restart = (st_nxt != st_r);

  // Divider restarts on each phase change; a free-running tick could cut the first ms short
  surge_time_ms #(.MS_DIV(MS_DIV)) u_ms (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN && !ms_restart),
    .tick_out(tick)
  );

  // ----------------------------------------
  // Peak power sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (trig) begin
          st_nxt = ST_OVLD;
        end
      end
      ST_OVLD: begin
        if (!mode_en || clr_ovld) begin
          st_nxt = ST_IDLE;
        end else if (ms_done) begin
          st_nxt = no_relax ? ST_IDLE : ST_RELAX;
        end
      end
      ST_RELAX: begin
        if (!mode_en || clr_relax || ms_done) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Register next value; flags mirror sequencer, writes never set them
  always_comb begin
    opt_nxt = opt_r;
    if (hit) begin
      opt_nxt = wr.wdata;
    end
    if (adapter_gone) begin
      opt_nxt[`BIT_TRIG_IN] = 1'b0;
      opt_nxt[`BIT_TRIG_SYS] = 1'b0;
    end
    opt_nxt[`BIT_OVLD_FLAG] = (st_nxt == ST_OVLD);
    opt_nxt[`BIT_RELAX_FLAG] = (st_nxt == ST_RELAX);
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      opt_r <= `OPT_REG_RESET;
      st_r <= ST_IDLE;
      adapter_d_r <= 1'b0;
    end else begin
      opt_r <= opt_nxt;
      st_r <= st_nxt;
      adapter_d_r <= ADAPTER_PRESENT_IN;
    end
  end

  // Phase length counter, reloaded on each phase entry
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      ms_r <= 6'h00;
    end else if (st_nxt != st_r) begin
      ms_r <= (st_nxt == ST_OVLD) ? ov_ms : relax_ms;
    end else if (tick && ms_r != 6'h00) begin
      ms_r <= ms_r - 6'h01;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN || !INPUT_OC_DETECT_IN || !opt_r[`BIT_INOC_EN]) begin
      blank_r <= 16'h0000;
    end else if (blank_r != 16'(BLANK)) begin
      blank_r <= blank_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Registered outputs to analog and host
  // ----------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= `OPT_REG_RESET;
      INPUT_LIMIT_OUT <= 16'h0000;
      MONITOR_CHARGE_OUT <= 1'b0;
      LOWSW_OC_MV_OUT <= 8'(`LOWSW_MV_1);
      INPUT_OC_MV_OUT <= 9'(`INOC_MV_1);
      INPUT_OC_RATIO_PCT_OUT <= 8'(`RATIO_PCT_1);
      DISCHARGE_OC_RATIO_PCT_OUT <= 8'(`RATIO_PCT_1);
      SURGE_ACTIVE_OUT <= 1'b0;
      CONVERTER_DISABLE_OUT <= 1'b0;
    end else begin
      RDATA_OUT <= opt_nxt;
      // Lower of pin and register limit when pin limit enabled, else register limit
      INPUT_LIMIT_OUT <= (opt_r[`BIT_PIN_LIM] && PIN_LIMIT_IN < REG_LIMIT_IN) ?
                         PIN_LIMIT_IN : REG_LIMIT_IN;
      MONITOR_CHARGE_OUT <= opt_r[`BIT_MON_DIR];
      LOWSW_OC_MV_OUT <= opt_r[`BIT_LOWSW] ? 8'(`LOWSW_MV_1) : 8'(`LOWSW_MV_0);
      INPUT_OC_MV_OUT <= opt_r[`BIT_INOC_SEL] ? 9'(`INOC_MV_1) : 9'(`INOC_MV_0);
      INPUT_OC_RATIO_PCT_OUT <= opt_r[`BIT_INOC_RATIO] ? 8'(`RATIO_PCT_1) : 8'(`RATIO_PCT_0);
      DISCHARGE_OC_RATIO_PCT_OUT <= opt_r[`BIT_DSOC_RATIO] ? 8'(`RATIO_PCT_1) :
                                    8'(`RATIO_PCT_0);
      SURGE_ACTIVE_OUT <= (st_r == ST_OVLD);
      CONVERTER_DISABLE_OUT <= (blank_r == 16'(BLANK)) ||
                               (opt_r[`BIT_DSOC_EN] && DISCHARGE_OC_DETECT_IN);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_ovld_enter;
    st_r == ST_IDLE && trig && !hit;
  endsequence
  property p_reset_default;
    @(posedge MCLK_IN) !RST_N_IN |=> opt_r == `OPT_REG_RESET;
  endproperty
  a_reset_default: assert property (p_reset_default) else $error("bad reset value");
  property p_enter;
    @(posedge MCLK_IN) disable iff (!RST_N_IN) s_ovld_enter |=> opt_r[`BIT_OVLD_FLAG];
  endproperty
  a_enter: assert property (p_enter) else $error("overload not entered");
  property p_no_trig;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      st_r == ST_IDLE && !opt_r[`BIT_TRIG_SYS] && !INPUT_OVERSHOOT_IN |=> st_r == ST_IDLE;
  endproperty
  a_no_trig: assert property (p_no_trig) else $error("spurious trigger");
  property p_off;
    @(posedge MCLK_IN) disable iff (!RST_N_IN) !mode_en |=> st_r == ST_IDLE;
  endproperty
  a_off: assert property (p_off) else $error("mode active while disabled");
  property p_clr_ovld;
    @(posedge MCLK_IN) disable iff (!RST_N_IN) st_r == ST_OVLD && clr_ovld |=> !opt_r[`BIT_OVLD_FLAG];
  endproperty
  a_clr_ovld: assert property (p_clr_ovld) else $error("overload not left");
  property p_clr_relax;
    @(posedge MCLK_IN) disable iff (!RST_N_IN) clr_relax |=> !opt_r[`BIT_RELAX_FLAG];
  endproperty
  a_clr_relax: assert property (p_clr_relax) else $error("relax not left");
  property p_no_relax;
    @(posedge MCLK_IN) disable iff (!RST_N_IN) st_r == ST_OVLD && no_relax |=> st_r != ST_RELAX;
  endproperty
  a_no_relax: assert property (p_no_relax) else $error("relax despite long overload");
  property p_limit;
    @(posedge MCLK_IN) disable iff (!RST_N_IN) 1'b1 |=> INPUT_LIMIT_OUT <= $past(REG_LIMIT_IN);
  endproperty
  a_limit: assert property (p_limit) else $error("limit above register");
  property p_batoc;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      opt_r[`BIT_DSOC_EN] && DISCHARGE_OC_DETECT_IN |=> CONVERTER_DISABLE_OUT;
  endproperty
  a_batoc: assert property (p_batoc) else $error("discharge fault ignored");
endmodule // surge_opts_reg

// *** verilog/surge_time_ms.sv ***
// Millisecond tick divider, restartable through its reset
`timescale 1ns/1ps
`include "surge_opts_params.svh"
module surge_time_ms #(
  parameter int MS_DIV = `MS_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic tick_out
);
  logic [23:0] cnt_r;
  // ----------------------------------------
  // One-cycle enable every millisecond
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cnt_r == 24'(MS_DIV - 1)) begin
      cnt_r <= 24'h000000;
    end else begin
      cnt_r <= cnt_r + 24'h000001;
    end
  end
  always_ff @(posedge clk_in) begin
    tick_out <= rst_n_in && (cnt_r == 24'(MS_DIV - 1));
  end
endmodule // surge_time_ms
